// file: core/fpo_top.sv
// flow pulse output generator with register port
`timescale 1ns/1ps
// Notes on behaviour
// - output use: frequency, error, or stroke
// - output stage sinking or sourcing selectable
// - frequency equals k factor times flow
// - rate taken from volume per second
// - behaviour switches at ten hertz
// - above ten hertz equal high and low
// - constant mode uses preset pulse width
// - flag error when gaps under width
// - overload holds output at maximum rate
// - overload raises error and orange indicator
// - setting routes error onto counter output
// - stroke out of range: stop, red indicator
// - simulation drives user frequency instead
// - menu held open while simulation active
// - open collector output up to 10 khz
module fpo_top
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire fpo_pkg::fpo_bus_t bus,
  output logic [31:0]          rdata,
  input  wire logic            vol_pulse,
  input  wire logic            stroke_evt,
  input  wire logic            stroke_ok,
  input  wire logic            fault_in,
  output logic                 pin_out,
  output logic                 pin_oe,
  output logic                 stat_orange,
  output logic                 stroke_red,
  output logic                 stroke_green,
  output logic                 menu_hold,
  output logic                 irq
);
  import fpo_pkg::*;

  // ******************************
  // input synchronisers
  // ******************************
  logic [3:0] s1_ff, s2_ff, s3_ff;
  logic [3:0] nxt_s1, nxt_s2, nxt_s3;
  always_comb begin
    nxt_s1 = {fault_in, stroke_ok, stroke_evt, vol_pulse};
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
  end
  always_ff @(posedge clk) begin
    s1_ff <= nxt_s1;
    s2_ff <= nxt_s2;
    s3_ff <= nxt_s3;
  end
  logic vol_evt, strk_evt, strk_ok, flt;
  assign vol_evt  = s2_ff[0] & ~s3_ff[0];
  assign strk_evt = s2_ff[1] & ~s3_ff[1];
  assign strk_ok  = s2_ff[2];
  assign flt      = s2_ff[3];

  // ******************************
  // registers
  // ******************************
  logic [7:0]  ctrl_ff, nxt_ctrl;
  logic [31:0] kfac_ff, nxt_kfac, width_ff, nxt_width, simf_ff, nxt_simf;
  logic [2:0]  irq_ff, nxt_irq, mask_ff, nxt_mask;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] freq_ff, nxt_freq;
  logic        ovl_ff, nxt_ovl;
  logic        range_bad_ff, nxt_range_bad;
  logic        tick;
  fpo_use_t    use_sel;
  logic        is_const, err_en, sim_on;
  assign use_sel  = fpo_use_t'(ctrl_ff[CTRL_USE_LSB +: 2]);
  assign is_const = ctrl_ff[CTRL_CONST_BIT];
  assign err_en   = ctrl_ff[CTRL_ERREN_BIT];
  assign sim_on   = ctrl_ff[CTRL_SIM_BIT];

  function automatic logic hit(input fpo_bus_t b, input logic [7:0] a);
    return b.wr && (b.addr == a);
  endfunction

  always_comb begin
    nxt_ctrl  = hit(bus, ADR_CTRL)  ? bus.wdata[7:0] : ctrl_ff;
    nxt_kfac  = hit(bus, ADR_KFAC)  ? bus.wdata : kfac_ff;
    nxt_width = hit(bus, ADR_WIDTH) ? bus.wdata : width_ff;
    nxt_simf  = hit(bus, ADR_SIMF)  ? bus.wdata : simf_ff;
    nxt_mask  = hit(bus, ADR_MASK)  ? bus.wdata[2:0] : mask_ff;
    nxt_irq   = irq_ff;
    if (hit(bus, ADR_IRQ)) begin
      nxt_irq = irq_ff & ~bus.wdata[2:0];
    end
    // set wins over clear
    nxt_irq = nxt_irq | {tick, nxt_range_bad & ~range_bad_ff, nxt_ovl & ~ovl_ff};
    nxt_rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        ADR_CTRL:  nxt_rdata = {24'h00_0000, ctrl_ff};
        ADR_KFAC:  nxt_rdata = kfac_ff;
        ADR_WIDTH: nxt_rdata = width_ff;
        ADR_SIMF:  nxt_rdata = simf_ff;
        ADR_STAT:  nxt_rdata = {29'h0, stroke_red, ovl_ff, pin_out};
        ADR_IRQ:   nxt_rdata = {29'h0, irq_ff};
        ADR_MASK:  nxt_rdata = {29'h0, mask_ff};
        ADR_FREQ:  nxt_rdata = freq_ff;
        default:   nxt_rdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff  <= CTRL_RST;
      kfac_ff  <= KFAC_RST;
      width_ff <= WIDTH_RST;
      simf_ff  <= 32'h0000_0000;
      mask_ff  <= ZERO3;
      irq_ff   <= ZERO3;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      kfac_ff  <= nxt_kfac;
      width_ff <= nxt_width;
      simf_ff  <= nxt_simf;
      mask_ff  <= nxt_mask;
      irq_ff   <= nxt_irq;
      rdata_ff <= nxt_rdata;
    end
  end

  // ******************************
  // one second volume window
  // ******************************
  logic [27:0] sec_ff, nxt_sec;
  logic [31:0] vcnt_ff, nxt_vcnt;
  logic [63:0] prod;
  assign tick = (sec_ff == 28'(RATE_CYC - 1));
  assign prod = 64'(kfac_ff) * 64'(vcnt_ff);
  always_comb begin
    nxt_sec  = tick ? 28'h0 : sec_ff + 28'h1;
    nxt_vcnt = tick ? 32'h0 : vcnt_ff + {31'h0, vol_evt};
    nxt_freq = freq_ff;
    if (sim_on) begin
      nxt_freq = (simf_ff > FMAX_HZ) ? FMAX_HZ : simf_ff;
    end else if (tick) begin
      nxt_freq = (prod > 64'(FMAX_HZ)) ? FMAX_HZ : prod[31:0];
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      sec_ff  <= 28'h0;
      vcnt_ff <= 32'h0;
      freq_ff <= 32'h0;
    end else begin
      sec_ff  <= nxt_sec;
      vcnt_ff <= nxt_vcnt;
      freq_ff <= nxt_freq;
    end
  end

  // ******************************
  // pulse generator
  // ******************************
  fpo_state_t  st_ff, nxt_st;
  logic [31:0] cnt_ff, nxt_cnt, half;
  logic [31:0] qacc_ff, nxt_qacc;
  logic        slow, start;
  logic [31:0] load;
  assign half = (freq_ff == 32'h0) ? 32'h0 : (CLK_HZ / 2) / freq_ff;
  assign slow = !is_const && (freq_ff <= THRESH_HZ) && !sim_on;
  always_comb begin
    nxt_ovl = is_const && (freq_ff != 32'h0) && (half < width_ff);
    nxt_range_bad = range_bad_ff;
    if (strk_evt) begin
      nxt_range_bad = !strk_ok;
    end
    // slow mode: one pulse per k factor quantum of volume
    nxt_qacc = qacc_ff + (vol_evt ? kfac_ff : 32'h0);
    // a quantum left over from another mode must not fire later
    if (!slow) begin
      nxt_qacc = 32'h0;
    end
    start = 1'b0;
    if (slow) begin
      start = (qacc_ff != 32'h0);
    end else begin
      start = (freq_ff != 32'h0);
    end
    // high time of the next pulse
    load = half;
    if (is_const) begin
      load = width_ff;
    end else if (slow) begin
      load = 32'(MIN_HALF_CYC);
    end
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_st  = ST_HIGH;
          nxt_cnt = load;
          if (slow) begin
            nxt_qacc = nxt_qacc - 32'h1;
          end
        end
      end
      ST_HIGH: begin
        if (cnt_ff <= 32'h1) begin
          nxt_st  = ST_LOW;
          // overload clamps low time to the width
          if (nxt_ovl) begin
            nxt_cnt = width_ff;
          end else if (is_const) begin
            nxt_cnt = half * 32'h2 - width_ff;
          end else begin
            nxt_cnt = load;
          end
        end else begin
          nxt_cnt = cnt_ff - 32'h1;
        end
      end
      ST_LOW: begin
        // back to back pulses skip idle so low equals high outside constant mode
        if (cnt_ff > 32'h1) begin
          nxt_cnt = cnt_ff - 32'h1;
        end else if (start) begin
          nxt_st  = ST_HIGH;
          nxt_cnt = load;
          if (slow) begin
            nxt_qacc = nxt_qacc - 32'h1;
          end
        end else begin
          nxt_st = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff        <= ST_IDLE;
      cnt_ff       <= 32'h0;
      qacc_ff      <= 32'h0;
      ovl_ff       <= 1'b0;
      range_bad_ff <= 1'b0;
    end else begin
      st_ff        <= nxt_st;
      cnt_ff       <= nxt_cnt;
      qacc_ff      <= nxt_qacc;
      ovl_ff       <= nxt_ovl;
      range_bad_ff <= nxt_range_bad;
    end
  end

  // ******************************
  // output stage
  // ******************************
  logic act, nxt_pin, nxt_oe, nxt_irq_o, nxt_orange, nxt_red, nxt_green, nxt_hold;
  logic pin_ff, oe_ff, irq_o_ff, orange_ff, red_ff, green_ff, hold_ff;
  always_comb begin
    case (use_sel)
      USE_ERROR:  act = err_en && (ovl_ff || flt);
      USE_STROKE: act = strk_evt && !nxt_range_bad;
      default:    act = (st_ff == ST_HIGH);
    endcase
    if (sim_on) begin
      act = (st_ff == ST_HIGH);
    end
    // sourcing drives high, sinking pulls low
    nxt_pin    = ctrl_ff[CTRL_SRC_BIT];
    nxt_oe     = act;
    nxt_irq_o  = |(nxt_irq & mask_ff);
    nxt_orange = nxt_ovl;
    nxt_red    = nxt_range_bad;
    nxt_green  = !nxt_range_bad;
    nxt_hold   = sim_on;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_ff    <= 1'b0;
      oe_ff     <= 1'b0;
      irq_o_ff  <= 1'b0;
      orange_ff <= 1'b0;
      red_ff    <= 1'b0;
      green_ff  <= 1'b0;
      hold_ff   <= 1'b0;
    end else begin
      pin_ff    <= nxt_pin;
      oe_ff     <= nxt_oe;
      irq_o_ff  <= nxt_irq_o;
      orange_ff <= nxt_orange;
      red_ff    <= nxt_red;
      green_ff  <= nxt_green;
      hold_ff   <= nxt_hold;
    end
  end
  assign pin_out      = pin_ff;
  assign pin_oe       = oe_ff;
  assign irq          = irq_o_ff;
  assign stat_orange  = orange_ff;
  assign stroke_red   = red_ff;
  assign stroke_green = green_ff;
  assign menu_hold    = hold_ff;
  assign rdata        = rdata_ff;
endmodule

// file: include/fpo_pkg.sv
// package for the flow pulse output block
package fpo_pkg;
  // ******************************
  // clock and timing
  // ******************************
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned RATE_MS     = 1000;
  localparam int unsigned RATE_CYC    = CLK_HZ / 1000 * RATE_MS;
  localparam int unsigned THRESH_HZ   = 10;
  localparam int unsigned FMAX_HZ     = 10000;
  localparam int unsigned MIN_HALF_CYC = CLK_HZ / (2 * FMAX_HZ);
  // ******************************
  // register map
  // ******************************
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_KFAC    = 8'h04;
  localparam logic [7:0] ADR_WIDTH   = 8'h08;
  localparam logic [7:0] ADR_SIMF    = 8'h0c;
  localparam logic [7:0] ADR_STAT    = 8'h10;
  localparam logic [7:0] ADR_IRQ     = 8'h14;
  localparam logic [7:0] ADR_MASK    = 8'h18;
  localparam logic [7:0] ADR_FREQ    = 8'h1c;
  // ctrl fields
  localparam int unsigned CTRL_USE_LSB  = 0;
  localparam int unsigned CTRL_SRC_BIT  = 2;
  localparam int unsigned CTRL_CONST_BIT = 3;
  localparam int unsigned CTRL_ERREN_BIT = 4;
  localparam int unsigned CTRL_SIM_BIT  = 5;
  // irq bits
  localparam int unsigned IRQ_OVL  = 0;
  localparam int unsigned IRQ_RANGE = 1;
  localparam int unsigned IRQ_TICK = 2;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [31:0] KFAC_RST  = 32'h0000_0001;
  localparam logic [31:0] WIDTH_RST = 32'h0000_0001;
  localparam logic [2:0]  ZERO3     = 3'h0;
  // ******************************
  // types
  // ******************************
  typedef enum logic [1:0] {
    USE_FREQ   = 2'h0,
    USE_ERROR  = 2'h1,
    USE_STROKE = 2'h3
  } fpo_use_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_HIGH = 2'h1,
    ST_LOW  = 2'h3
  } fpo_state_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fpo_bus_t;
endpackage

// file: tb/fpo_far_end.sv
// open collector receiver model on the counter output
`timescale 1ns/1ps
module fpo_far_end (
  input  wire logic clk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      line_lvl,
  output int        pulse_cnt
);
  logic oe_q = 1'b0;
  // ******************************
  // line level
  // ******************************
  // sinking pulls low against pull-up, sourcing drives high against pull-down
  assign line_lvl = pin_oe ? pin_out : ~pin_out;
  initial pulse_cnt = 0;
  always @(posedge clk) begin
    oe_q <= pin_oe;
    if (pin_oe && !oe_q) begin
      pulse_cnt <= pulse_cnt + 1;
    end
  end
endmodule

// file: tb/fpo_top_monitor.sv
// concurrent checks on the flow pulse output ports
`timescale 1ns/1ps
module fpo_top_checker
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire fpo_pkg::fpo_bus_t bus,
  input  wire logic [31:0]       rdata,
  input  wire logic              pin_out,
  input  wire logic              stroke_red,
  input  wire logic              stroke_green,
  input  wire logic              menu_hold
);
  import fpo_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ******************************
  // assertions
  // ******************************
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  a_unmapped_zero: assert property (bus.rd && bus.addr == 8'h20 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_width: assert property ($past(bus.rd && bus.addr == ADR_CTRL)
    |-> rdata[31:8] == 24'h0)
    else $error("control readback too wide");
  a_freq_cap: assert property ($past(bus.rd && bus.addr == ADR_FREQ) |-> rdata <= FMAX_HZ)
    else $error("frequency above maximum");
  a_menu_rise: assert property (bus.wr && bus.addr == ADR_CTRL && bus.wdata[CTRL_SIM_BIT]
    |-> ##[1:2] menu_hold)
    else $error("menu hold not raised");
  a_menu_cause: assert property ($changed(menu_hold)
    |-> $past(bus.wr && bus.addr == ADR_CTRL) || $past(bus.wr && bus.addr == ADR_CTRL, 2))
    else $error("menu hold changed without control write");
  a_stage_cause: assert property ($changed(pin_out)
    |-> $past(bus.wr && bus.addr == ADR_CTRL) || $past(bus.wr && bus.addr == ADR_CTRL, 2))
    else $error("output stage changed without control write");
  a_led_exclusive: assert property (!$past(rst) |-> stroke_red != stroke_green)
    else $error("stroke indicator not exactly one colour");
endmodule
bind fpo_top fpo_top_checker u_chk (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
  .pin_out(pin_out), .stroke_red(stroke_red), .stroke_green(stroke_green),
  .menu_hold(menu_hold));

// file: tb/fpo_top_test.sv
// self-checking bench for the flow pulse output block
`timescale 1ns/1ps
module fpo_top_test;
  import fpo_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  fpo_bus_t    bus = '0;
  logic [31:0] rdata;
  logic        vol_pulse = 1'b0;
  logic        stroke_evt = 1'b0;
  logic        stroke_ok = 1'b1;
  logic        fault_in = 1'b0;
  logic        pin_out, pin_oe, stat_orange, stroke_red, stroke_green, menu_hold, irq;
  logic        line_lvl;
  int          pulse_cnt;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [39:0] rows [6] = '{{8'h00, 32'h23}, {8'h04, 32'h7}, {8'h08, 32'h9},
                            {8'h0c, 32'h5}, {8'h18, 32'h7}, {8'h20, 32'h0}};
  logic [31:0] exps [6] = '{32'h23, 32'h7, 32'h9, 32'h5, 32'h7, 32'h0};
  always #2.5 clk = ~clk;
  fpo_top u_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .vol_pulse(vol_pulse),
    .stroke_evt(stroke_evt), .stroke_ok(stroke_ok), .fault_in(fault_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .stat_orange(stat_orange), .stroke_red(stroke_red),
    .stroke_green(stroke_green), .menu_hold(menu_hold), .irq(irq));
  fpo_far_end u_far (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .line_lvl(line_lvl),
    .pulse_cnt(pulse_cnt));
  // ******************************
  // tasks
  // ******************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 check("rdata", rdata, exp);
  endtask
  task automatic stroke(input logic ok);
    @(posedge clk);
    stroke_ok <= ok;
    stroke_evt <= 1'b1;
    repeat (6) @(posedge clk);
    stroke_evt <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic next_rise;
    while (pin_oe === 1'b1) begin
      @(posedge clk);
      #1;
    end
    while (pin_oe !== 1'b1) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic span(input logic lvl, output int len);
    len = 0;
    while (pin_oe === lvl) begin
      @(posedge clk);
      #1 len++;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ******************************
  // sequence
  // ******************************
  initial begin
    int n, hi, lo;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1 check("oe after reset", {31'h0, pin_oe}, 32'h0);
    rd(ADR_CTRL, {24'h0, CTRL_RST});
    rd(ADR_KFAC, KFAC_RST);
    rd(ADR_WIDTH, WIDTH_RST);
    rd(ADR_IRQ, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i][39:32], rows[i][31:0]);
      rd(rows[i][39:32], exps[i]);
    end
    repeat (2) @(posedge clk);
    #1 check("menu hold", {31'h0, menu_hold}, 32'h1);
    check("stage", {31'h0, pin_out}, 32'h0);
    wr(ADR_CTRL, 32'h07);
    repeat (2) @(posedge clk);
    #1 check("sourcing stage", {31'h0, pin_out}, 32'h1);
    check("menu released", {31'h0, menu_hold}, 32'h0);
    n = pulse_cnt;
    stroke(1'b1);
    check("stroke forwarded", pulse_cnt - n, 32'h1);
    check("green", {31'h0, stroke_green}, 32'h1);
    wr(ADR_MASK, 32'h2);
    n = pulse_cnt;
    stroke(1'b0);
    check("bad stroke blocked", pulse_cnt - n, 32'h0);
    check("red", {31'h0, stroke_red}, 32'h1);
    check("irq raised", {31'h0, irq}, 32'h1);
    wr(ADR_IRQ, 32'h2);
    repeat (2) @(posedge clk);
    #1 check("irq cleared", {31'h0, irq}, 32'h0);
    wr(ADR_CTRL, 32'h11);
    fault_in <= 1'b1;
    for (int i = 0; i < 20 && pin_oe !== 1'b1; i++) @(posedge clk);
    #1 check("error signalled", {31'h0, pin_oe}, 32'h1);
    check("sinking line low", {31'h0, line_lvl}, 32'h0);
    wr(ADR_CTRL, 32'h01);
    repeat (6) @(posedge clk);
    #1 check("error suppressed", {31'h0, pin_oe}, 32'h0);
    // ******************************
    // mid-run reset and pulse timing
    // ******************************
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 check("oe after second reset", {31'h0, pin_oe}, 32'h0);
    check("red after reset", {31'h0, stroke_red}, 32'h0);
    rd(ADR_CTRL, {24'h0, CTRL_RST});
    rd(ADR_STAT, 32'h0);
    wr(ADR_WIDTH, 32'h0000_2711);
    wr(ADR_SIMF, 32'h0000_2710);
    wr(ADR_CTRL, 32'h28);
    next_rise();
    span(1'b1, hi);
    span(1'b0, lo);
    check("fixed high", hi, 32'h0000_2711);
    check("clamped low", lo, 32'h0000_2711);
    check("orange", {31'h0, stat_orange}, 32'h1);
    rd(ADR_STAT, 32'h2);
    rd(ADR_IRQ, 32'h1);
    rd(ADR_FREQ, 32'h0000_2710);
    wr(ADR_CTRL, 32'h20);
    next_rise();
    span(1'b1, hi);
    span(1'b0, lo);
    check("square high", hi, CLK_HZ / (2 * 32'h2710));
    check("square low", lo, CLK_HZ / (2 * 32'h2710));
    check("orange cleared", {31'h0, stat_orange}, 32'h0);
    report_and_stop();
  end
endmodule
